// ==== hw/tsl_pkg.sv ====
// Shared constants and carrier types for the time slot loopback switch.
// Assumes a 125 MHz system clock and one byte per time slot per cycle.
package tsl_pkg;

   // ----------------------------------------------------------------
   // Frame geometry
   // ----------------------------------------------------------------
   localparam int SLOT_BITS = 5;
   localparam int SLOTS = 32;
   localparam logic [4:0] SLOT_LAST = 5'h1F;

   // ----------------------------------------------------------------
   // Register offsets and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_DATA = 8'h00;
   localparam logic [7:0] OFF_ADDR = 8'h04;
   localparam logic [7:0] OFF_CTRL = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0C;
   localparam logic [7:0] REG_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Field positions and codes
   // ----------------------------------------------------------------
   localparam int DIR_BIT = 7;
   localparam int MOC_MSB = 7;
   localparam int MOC_LSB = 4;
   localparam logic [3:0] MOC_TRISTATE = 4'h6;
   localparam logic [3:0] MOC_CONNECT = 4'h7;
   localparam logic [3:0] CODE_UNASSIGNED = 4'h0;
   localparam logic [3:0] CODE_FULL = 4'h1;
   localparam logic [3:0] TS_ALL_HIGHZ = 4'h0;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ptr;
      logic [3:0] code;
   } tsl_cm_entry_type;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] oe;
   } tsl_lane_type;

endpackage

// ==== hw/tsl_cm_ram.sv ====
// One control memory: an entry per configurable-port time slot.
// Assumes writes come from the register logic, reads from the slot counter.
`timescale 1ns/1ps
module tsl_cm_ram (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Write port
   input wire logic we_i,
   input wire logic [4:0] waddr_i,
   input wire tsl_pkg::tsl_cm_entry_type wdata_i,
   // Read port
   input wire logic [4:0] raddr_i,
   output tsl_pkg::tsl_cm_entry_type rdata_o
);

   tsl_pkg::tsl_cm_entry_type mem [tsl_pkg::SLOTS];

   // Reset leaves every slot unassigned, so no output is driven until programmed.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < tsl_pkg::SLOTS; i++) begin
            mem[i] <= '0;
         end
      end else if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   assign rdata_o = mem[raddr_i];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_store;
      @(posedge clk_i) disable iff (rst_i)
      we_i |=> mem[$past(waddr_i)] == $past(wdata_i);
   endproperty
   a_store: assert property (p_store) else $error("control memory entry not stored"); // RULE4

endmodule

// ==== hw/tsl_switch.sv ====
// Time slot switch core with loopback through the opposite interface.
// Assumes a classic Wishbone master and byte-wide slot streams in step with rx_slot_o.
//
// Overview of operation
// (RULE1) Host programs CONFIGURABLE_SERIAL_PORT loop as two connections.
// (RULE2) First CONFIGURABLE_SERIAL_PORT connection: spare PCM pointer upstream.
// (RULE3) Tristate field decides highway visibility of loop.
// (RULE4) Second connection reuses pointer in downstream memory.
// (RULE5) Downstream output fetches looped byte from upstream memory.
// (RULE6) First PCM connection: pointer into downstream memory.
// (RULE7) Code zero hides, nonzero shows subscriber output.
// (RULE8) Second PCM connection: pointer MSB cleared upstream.
// (RULE9) Leading zero pointer feeds downstream output upstream.
// (RULE10) Operation 0110 writes slot tristate field.
// (RULE11) Operation 0111 0001 stores full channel connection.
// (RULE12) Operation 0111 0000 stores unassigned connection.
// (RULE13) Loops borrow opposite-side slot, may be high-Z.
// (RULE14) Host keeps borrowed slot free while looping.
`timescale 1ns/1ps
module tsl_switch (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Slot timing
   output logic [4:0] rx_slot_o,
   output logic [4:0] tx_slot_o,
   // Highway side
   input wire logic [7:0] pcm_rx_i,
   output tsl_pkg::tsl_lane_type pcm_tx_o,
   // Subscriber side
   input wire logic [7:0] configurable_serial_port_up_i,
   output logic [7:0] subscriber_downstream_out_o,
   output logic subscriber_downstream_out_oe_o
);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [7:0] memory_access_data_reg;
   logic [7:0] memory_access_address_reg;
   logic [7:0] memory_access_control_reg;
   logic bad_op;
   logic [7:0] next_data_reg;
   logic [7:0] next_address_reg;
   logic [7:0] next_control_reg;
   logic next_bad_op;
   logic next_ack;
   logic [31:0] next_dat;
   logic commit;
   logic op_go;
   logic [3:0] memory_operation_code;
   logic cm_up_we;
   logic cm_down_we;
   logic ts_we;
   tsl_pkg::tsl_cm_entry_type cm_wdata;
   logic [4:0] slot;
   logic [4:0] next_slot;

   // A write lands only at the edge where ack is seen high, as the master expects.
   assign commit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign op_go = commit && (wb_adr_i == tsl_pkg::OFF_CTRL);
   assign memory_operation_code = wb_dat_i[tsl_pkg::MOC_MSB:tsl_pkg::MOC_LSB];
   assign cm_wdata = '{ptr: memory_access_data_reg, code: wb_dat_i[3:0]};
   // The direction bit of the address picks the upstream or downstream memory.
   assign cm_up_we = op_go && (memory_operation_code == tsl_pkg::MOC_CONNECT)
                     && memory_access_address_reg[tsl_pkg::DIR_BIT]; // RULE2
   assign cm_down_we = op_go && (memory_operation_code == tsl_pkg::MOC_CONNECT)
                       && !memory_access_address_reg[tsl_pkg::DIR_BIT]; // RULE4
   assign ts_we = op_go && (memory_operation_code == tsl_pkg::MOC_TRISTATE); // RULE10

   always_comb begin
      next_data_reg = memory_access_data_reg;
      next_address_reg = memory_access_address_reg;
      next_control_reg = memory_access_control_reg;
      next_bad_op = bad_op;
      next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      next_dat = wb_dat_o;
      if (commit) begin
         unique case (wb_adr_i)
            tsl_pkg::OFF_DATA: next_data_reg = wb_dat_i[7:0];
            tsl_pkg::OFF_ADDR: next_address_reg = wb_dat_i[7:0];
            tsl_pkg::OFF_CTRL: begin
               next_control_reg = wb_dat_i[7:0];
               next_bad_op = !(ts_we || cm_up_we || cm_down_we);
            end
            default: next_bad_op = bad_op;
         endcase
      end
      if (next_ack) begin
         unique case (wb_adr_i)
            tsl_pkg::OFF_DATA: next_dat = {24'h00_0000, memory_access_data_reg};
            tsl_pkg::OFF_ADDR: next_dat = {24'h00_0000, memory_access_address_reg};
            tsl_pkg::OFF_CTRL: next_dat = {24'h00_0000, memory_access_control_reg};
            tsl_pkg::OFF_STAT: next_dat = {26'h000_0000, bad_op, slot};
            default: next_dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         memory_access_data_reg <= tsl_pkg::REG_RESET;
         memory_access_address_reg <= tsl_pkg::REG_RESET;
         memory_access_control_reg <= tsl_pkg::REG_RESET;
         bad_op <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         memory_access_data_reg <= next_data_reg;
         memory_access_address_reg <= next_address_reg;
         memory_access_control_reg <= next_control_reg;
         bad_op <= next_bad_op;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // ----------------------------------------------------------------
   // Memories
   // ----------------------------------------------------------------
   tsl_pkg::tsl_cm_entry_type up_ent;
   tsl_pkg::tsl_cm_entry_type dn_ent;
   logic [7:0] data_memory_up [tsl_pkg::SLOTS];
   logic [7:0] data_memory_down [tsl_pkg::SLOTS];
   logic [3:0] tristate_field [tsl_pkg::SLOTS];

   tsl_cm_ram u_cm_up (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(cm_up_we),
      .waddr_i(memory_access_address_reg[4:0]),
      .wdata_i(cm_wdata),
      .raddr_i(slot),
      .rdata_o(up_ent)
   );

   tsl_cm_ram u_cm_down (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(cm_down_we),
      .waddr_i(memory_access_address_reg[4:0]),
      .wdata_i(cm_wdata),
      .raddr_i(slot),
      .rdata_o(dn_ent)
   );

   // ----------------------------------------------------------------
   // Switching datapath
   // ----------------------------------------------------------------
   logic [7:0] dn_byte;
   logic dd_drive;
   logic [7:0] up_byte;
   logic up_store;
   logic [7:0] tx_oe;

   always_comb begin
      // A set pointer MSB sources the subscriber slot from upstream memory.
      dn_byte = dn_ent.ptr[tsl_pkg::DIR_BIT] ? data_memory_up[dn_ent.ptr[4:0]]
                                             : data_memory_down[dn_ent.ptr[4:0]]; // RULE5
      dd_drive = dn_ent.code != tsl_pkg::CODE_UNASSIGNED; // RULE7 RULE12
      // The internal output is looped even when the pin is released.
      up_byte = up_ent.ptr[tsl_pkg::DIR_BIT] ? configurable_serial_port_up_i : dn_byte; // RULE9
      up_store = up_ent.code != tsl_pkg::CODE_UNASSIGNED; // RULE11
      next_slot = (slot == tsl_pkg::SLOT_LAST) ? 5'h00 : slot + 5'h01;
      for (int k = 0; k < 4; k++) begin
         tx_oe[2 * k +: 2] = {2{tristate_field[slot][k]}}; // RULE3 RULE13
      end
   end

   // Data memories hold one frame; a read before the write of the same slot
   // returns the previous frame, which is the price of a single buffer.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < tsl_pkg::SLOTS; i++) begin
            data_memory_up[i] <= 8'h00;
            data_memory_down[i] <= 8'h00;
            tristate_field[i] <= tsl_pkg::TS_ALL_HIGHZ;
         end
         slot <= 5'h00;
         tx_slot_o <= 5'h00;
         pcm_tx_o <= '0;
         subscriber_downstream_out_o <= 8'h00;
         subscriber_downstream_out_oe_o <= 1'b0;
      end else begin
         data_memory_down[slot] <= pcm_rx_i;
         if (up_store) begin
            data_memory_up[up_ent.ptr[4:0]] <= up_byte; // RULE9
         end
         if (ts_we) begin
            tristate_field[memory_access_address_reg[4:0]] <= memory_access_data_reg[3:0]; // RULE10
         end
         slot <= next_slot;
         tx_slot_o <= slot;
         pcm_tx_o <= '{data: data_memory_up[slot], oe: tx_oe};
         subscriber_downstream_out_o <= dn_byte;
         subscriber_downstream_out_oe_o <= dd_drive;
      end
   end

   assign rx_slot_o = slot;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   sequence s_ack_once;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   property p_bus_answer;
      @(posedge clk_i) disable iff (rst_i)
      s_req |=> s_ack_once;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle"); // RULE11

   property p_tristate_write;
      @(posedge clk_i) disable iff (rst_i)
      ts_we |=> tristate_field[$past(memory_access_address_reg[4:0])]
                == $past(memory_access_data_reg[3:0]);
   endproperty
   a_tristate_write: assert property (p_tristate_write) // RULE10
      else $error("tristate not stored");

   property p_full_code;
      @(posedge clk_i) disable iff (rst_i)
      (op_go && wb_dat_i[7:0] == {tsl_pkg::MOC_CONNECT, tsl_pkg::CODE_FULL}) |=>
         ($past(memory_access_address_reg[tsl_pkg::DIR_BIT])
            ? u_cm_up.mem[$past(memory_access_address_reg[4:0])]
            : u_cm_down.mem[$past(memory_access_address_reg[4:0])])
         == {$past(memory_access_data_reg), tsl_pkg::CODE_FULL};
   endproperty
   a_full_code: assert property (p_full_code) else $error("connect op not decoded"); // RULE11

   property p_unassigned_quiet;
      @(posedge clk_i) disable iff (rst_i)
      (dn_ent.code == tsl_pkg::CODE_UNASSIGNED) |=> !subscriber_downstream_out_oe_o;
   endproperty
   a_unassigned_quiet: assert property (p_unassigned_quiet) // RULE12
      else $error("unassigned slot driven");

   property p_assigned_drive;
      @(posedge clk_i) disable iff (rst_i)
      (dn_ent.code != tsl_pkg::CODE_UNASSIGNED) |=> subscriber_downstream_out_oe_o;
   endproperty
   a_assigned_drive: assert property (p_assigned_drive) // RULE7
      else $error("assigned slot not driven");

   property p_up_source;
      @(posedge clk_i) disable iff (rst_i)
      dn_ent.ptr[tsl_pkg::DIR_BIT] |=>
         subscriber_downstream_out_o == $past(data_memory_up[dn_ent.ptr[4:0]]);
   endproperty
   a_up_source: assert property (p_up_source) else $error("loop not fed from upstream"); // RULE5

   property p_loop_feed;
      @(posedge clk_i) disable iff (rst_i)
      (up_store && !up_ent.ptr[tsl_pkg::DIR_BIT]) |=>
         data_memory_up[$past(up_ent.ptr[4:0])] == $past(dn_byte);
   endproperty
   a_loop_feed: assert property (p_loop_feed) else $error("loop byte not stored"); // RULE9

   property p_tx_enable;
      @(posedge clk_i) disable iff (rst_i)
      (tristate_field[slot] == tsl_pkg::TS_ALL_HIGHZ) |=>
         pcm_tx_o.oe == 8'h00 ##1 tx_slot_o != $past(tx_slot_o);
   endproperty
   a_tx_enable: assert property (p_tx_enable) else $error("high impedance slot driven"); // RULE3

endmodule

// ==== tb/tsl_far_end.sv ====
// Far-end model: highway and subscriber transceivers, one byte per slot.
// Assumes rx_slot_i is the switch's receive slot counter.
`timescale 1ns/1ps
module tsl_far_end (
   // Slot timing
   input wire logic [4:0] rx_slot_i,
   // Line bytes
   output logic [7:0] pcm_rx_o,
   output logic [7:0] cfi_up_o
);
   // Each byte carries its own slot number, so a misrouted slot shows at once.
   always_comb begin
      pcm_rx_o = {3'b101, rx_slot_i};
      cfi_up_o = {3'b010, rx_slot_i};
   end
endmodule

// ==== tb/tsl_switch_tb.sv ====
// Self-checking bench for the loopback switch.
// Assumes the far-end model supplies line bytes and the bench is the Wishbone host.
`timescale 1ns/1ps
module tsl_switch_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [4:0] rx_slot_o;
   logic [4:0] tx_slot_o;
   logic [7:0] pcm_rx;
   logic [7:0] cfi_up;
   tsl_pkg::tsl_lane_type pcm_tx_o;
   logic [7:0] sub_o;
   logic sub_oe_o;
   logic [31:0] rd;
   int errors = 0;
   int num_checks = 0;

   always #4 clk_i = ~clk_i;

   tsl_switch uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .rx_slot_o(rx_slot_o), .tx_slot_o(tx_slot_o), .pcm_rx_i(pcm_rx),
      .pcm_tx_o(pcm_tx_o), .configurable_serial_port_up_i(cfi_up),
      .subscriber_downstream_out_o(sub_o), .subscriber_downstream_out_oe_o(sub_oe_o));

   tsl_far_end far (.rx_slot_i(rx_slot_o), .pcm_rx_o(pcm_rx), .cfi_up_o(cfi_up));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h00_0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      chk({15'h0000, wb_ack_o}, 16'h0001, "bus answer missing");
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
      chk({15'h0000, wb_ack_o}, 16'h0000, "bus answer held too long");
   endtask

   // Data and address go first because the control write executes the operation.
   task automatic prog(input logic [7:0] d, input logic [7:0] a, input logic [7:0] c);
      wb(1'b1, tsl_pkg::OFF_DATA, d);
      wb(1'b1, tsl_pkg::OFF_ADDR, a);
      wb(1'b1, tsl_pkg::OFF_CTRL, c);
   endtask

   // Two frames let the one-frame buffer refill before outputs are judged.
   task automatic at_slot(input logic [4:0] s);
      int n;
      n = 0;
      repeat (64) @(posedge clk_i);
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (tx_slot_o !== s && n < 40);
      chk({11'h000, tx_slot_o}, {11'h000, s}, "slot not reached");
      chk({11'h000, rx_slot_o}, {11'h000, s + 5'h01}, "receive slot not one ahead");
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      chk(pcm_tx_o, 16'h0000, "highway idle after reset");
      chk({7'h00, sub_oe_o, sub_o}, 16'h0000, "subscriber idle after reset");
      wb(1'b0, tsl_pkg::OFF_DATA, 8'h00);
      chk(rd[15:0], 16'h0000, "data register reset");
      wb(1'b0, 8'h10, 8'h00);
      chk(rd[15:0], 16'h0000, "unmapped read");
   endtask

   task automatic t_cfi_loop;
      prog(8'h80, 8'h94, 8'h71);
      prog(8'h80, 8'h1B, 8'h71);
      prog(8'h00, 8'h80, 8'h60);
      at_slot(5'h00);
      chk({8'h00, pcm_tx_o.oe}, 16'h0000, "non-transparent loop drives highway");
      at_slot(5'h1B);
      chk({7'h00, sub_oe_o, sub_o}, 16'h0154, "looped byte at subscriber");
      prog(8'h0F, 8'h80, 8'h60);
      at_slot(5'h00);
      chk(pcm_tx_o, 16'h54FF, "transparent loop on highway");
   endtask

   task automatic t_pcm_loop;
      prog(8'h0D, 8'h04, 8'h70);
      prog(8'h05, 8'h84, 8'h71);
      prog(8'h0F, 8'h85, 8'h60);
      at_slot(5'h04);
      chk({15'h0000, sub_oe_o}, 16'h0000, "unassigned slot driven");
      at_slot(5'h05);
      chk(pcm_tx_o, 16'hADFF, "looped byte on highway");
      prog(8'h0D, 8'h04, 8'h71);
      at_slot(5'h04);
      chk({7'h00, sub_oe_o, sub_o}, 16'h01AD, "transparent loop at subscriber");
      at_slot(5'h05);
      chk(pcm_tx_o, 16'hADFF, "loop kept after recode");
   endtask

   task automatic t_bad_op;
      prog(8'h00, 8'h1F, 8'h30);
      wb(1'b0, tsl_pkg::OFF_STAT, 8'h00);
      chk({15'h0000, rd[5]}, 16'h0001, "bad operation flag");
      prog(8'h00, 8'h1F, 8'h70);
      wb(1'b0, tsl_pkg::OFF_STAT, 8'h00);
      chk({15'h0000, rd[5]}, 16'h0000, "bad operation flag cleared");
   endtask

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      t_reset();
      t_cfi_loop();
      t_pcm_loop();
      t_bad_op();
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      stop_test();
   end
endmodule
